// >>> mcdc_defines.vh
// Purpose: constants for modulator clock and decimation control
// Assumes: 16-bit register port, word index addressing
// Notes:   all offsets are register indices on the plain port
`ifndef MCDC_DEFINES_VH
`define MCDC_DEFINES_VH

`define MCDC_AW             4
`define MCDC_DW             16

`define MCDC_ADDR_CLOCK     4'h0
`define MCDC_ADDR_CONV      4'h1
`define MCDC_ADDR_CH0       4'h2
`define MCDC_ADDR_CH1       4'h3
`define MCDC_ADDR_CH2       4'h4
`define MCDC_ADDR_STATUS    4'h5

`define MCDC_PWR_LSB        0
`define MCDC_DIV_LSB        2
`define MCDC_OSR_LSB        4
`define MCDC_TURBO_BIT      7
`define MCDC_STBY_BIT       8
`define MCDC_CLOCK_MASK     16'h01FF
`define MCDC_CLOCK_RST      16'h0100
`define MCDC_CONV_RST       4'h0
`define MCDC_CHSEL_RST      2'h0

`define MCDC_PWR_HR         2'h0
`define MCDC_PWR_LP         2'h1

`define MCDC_SEL_INPUT      2'h0
`define MCDC_SEL_GND        2'h1
`define MCDC_SEL_TPOS       2'h2
`define MCDC_SEL_TNEG       2'h3

`define MCDC_DIV_2          2'h0
`define MCDC_DIV_4          2'h1
`define MCDC_DIV_8          2'h2
`define MCDC_DIV_12         2'h3
`define MCDC_HALF_2         3'h1
`define MCDC_HALF_4         3'h2
`define MCDC_HALF_8         3'h4
`define MCDC_HALF_12        3'h6

`define MCDC_OSR_TURBO      15'h0040
`define MCDC_OSR_BASE       15'h0080

`define MCDC_TEST_MOD       5'h1E
`define MCDC_TEST_STEP      5'h11

`define MCDC_MAIN_KHZ       16'h2000

`endif

// >>> mcdc_clkdiv.v
// Purpose: divides the main clock into a 50% modulator clock
// Assumes: ratio select is stable or changes only between periods
// Notes:   new ratio is picked up at the start of each period
`timescale 1ns/10ps
`include "mcdc_defines.vh"

module mcdc_clkdiv (
   core_clk,
   rst_n,
   ce,
   div_sel,
   modulator_clock_r,
   mod_tick_r
);
   input  wire       core_clk;
   input  wire       rst_n;
   input  wire       ce;
   input  wire [1:0] div_sel;
   output reg        modulator_clock_r;
   output reg        mod_tick_r;

   reg  [2:0] cnt_r;
   reg  [2:0] half_r;
   reg  [2:0] half_nxt;

   always @* begin
      case (div_sel)   // [R7]
         `MCDC_DIV_2:  half_nxt = `MCDC_HALF_2;
         `MCDC_DIV_4:  half_nxt = `MCDC_HALF_4;
         `MCDC_DIV_8:  half_nxt = `MCDC_HALF_8;
         `MCDC_DIV_12: half_nxt = `MCDC_HALF_12;
         default:      half_nxt = `MCDC_HALF_2;
      endcase
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_r      <= 3'h0;
         half_r     <= `MCDC_HALF_2;   // [R6]
         modulator_clock_r  <= 1'b0;
         mod_tick_r <= 1'b0;
      end else if (ce) begin
         mod_tick_r <= 1'b0;
         if (cnt_r == half_r - 3'h1) begin
            cnt_r     <= 3'h0;
            modulator_clock_r <= ~modulator_clock_r;   // [R6]
            if (modulator_clock_r) begin
               // Only switch ratio at a period start, so no runt pulse
               half_r     <= half_nxt;
               mod_tick_r <= 1'b1;
            end
         end else begin
            cnt_r <= cnt_r + 3'h1;
         end
      end
   end
endmodule // mcdc_clkdiv

// >>> mcdc_ctrl.v
// Purpose: modulator clock, power mode, converter sync and decimation
// Assumes: core_clk is the main clock, modulator bits are synchronous
// Notes:   decimator counts ones over one oversampling window
// How it works
// R1 - Each channel select field can route a shared positive or negative test stream.
// R2 - Test stream density gives two fifteenths of full scale at any gain.
// R3 - Host keeps the main clock running all through normal operation.
// R4 - Two-bit power mode field picks high-resolution or low-power bias.
// R5 - Host keeps the main clock inside the range for the power mode.
// R6 - Modulator clock is the main clock divided, by two after reset, 50% duty.
// R7 - Divider field: 00 by 2, 01 by 4, 10 by 8, 11 by 12.
// R8 - Host writes the matching converter frequency code right after power-up.
// R9 - Frequency code maps sixteen descending modulator clock ranges.
// R10 - Each channel takes one bit per modulator clock into its filter.
// R11 - Averaging filter decimates from modulator rate by the ratio.
// R12 - Ratio field selects 128 to 16384; turbo bit selects 64.
// R13 - Host changes the ratio only in standby.
// R14 - Output rate is modulator rate over ratio, e.g. 4.096 MHz over 64.
// R15 - Divider field resets to 00, divide by two.
`timescale 1ns/10ps
`include "mcdc_defines.vh"

module mcdc_ctrl #(
   parameter [15:0] MAIN_CLK_KHZ = `MCDC_MAIN_KHZ
) (
   core_clk,
   rst_n,
   ce,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   mod_bit_in,
   modulator_clock,
   high_resolution_mode,
   low_power_mode,
   converter_freq_code,
   data_ch0,
   data_ch1,
   data_ch2,
   data_valid
);
   input  wire        core_clk;
   input  wire        rst_n;
   input  wire        ce;
   input  wire [3:0]  reg_addr;
   input  wire [15:0] reg_wdata;
   input  wire        reg_wr;
   input  wire        reg_rd;
   output reg  [15:0] reg_rdata;
   input  wire [2:0]  mod_bit_in;
   output wire        modulator_clock;
   output reg         high_resolution_mode;
   output reg         low_power_mode;
   output wire [3:0]  converter_freq_code;
   output wire [14:0] data_ch0;
   output wire [14:0] data_ch1;
   output wire [14:0] data_ch2;
   output reg         data_valid;

   // Nominal rates per divider, used only for the range flag
   localparam [15:0] FMOD_2  = MAIN_CLK_KHZ / 16'h0002;
   localparam [15:0] FMOD_4  = MAIN_CLK_KHZ / 16'h0004;
   localparam [15:0] FMOD_8  = MAIN_CLK_KHZ / 16'h0008;
   localparam [15:0] FMOD_12 = MAIN_CLK_KHZ / 16'h000C;

   reg  [15:0] clock_cfg_r;
   reg  [3:0]  conv_code_r;
   reg  [5:0]  ch_sel_r;
   reg  [14:0] win_cnt_r;
   reg  [4:0]  test_acc_r;
   reg         test_pos_r;
   reg         gnd_bit_r;
   reg         range_ok_r;
   reg  [15:0] rdata_nxt;
   reg  [14:0] osr_len;
   reg  [15:0] fmod_khz;
   reg  [15:0] lo_khz;
   reg  [15:0] hi_khz;
   reg  [5:0]  test_sum;
   wire        mod_tick;
   wire        standby;
   wire        win_end;
   wire        clk_wr;
   wire        range_lo_ok;
   wire        range_hi_ok;
   wire [44:0] data_w;

   assign standby             = clock_cfg_r[`MCDC_STBY_BIT];
   assign converter_freq_code = conv_code_r;
   assign clk_wr              = reg_wr && (reg_addr == `MCDC_ADDR_CLOCK);
   assign range_lo_ok         = (fmod_khz >= lo_khz);   // [R9]
   assign range_hi_ok         = (fmod_khz <= hi_khz);   // [R9]
   assign win_end             = (win_cnt_r == osr_len - 15'h0001);
   assign data_ch0            = data_w[14:0];
   assign data_ch1            = data_w[29:15];
   assign data_ch2            = data_w[44:30];

   // Divider runs in standby too, so the status clock bit stays live
   mcdc_clkdiv u_div (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .ce         (ce),
      .div_sel    (clock_cfg_r[`MCDC_DIV_LSB +: 2]),
      .modulator_clock_r  (modulator_clock),
      .mod_tick_r (mod_tick)
   );

   // Ratio decode; turbo overrides the ratio field
   always @* begin
      if (clock_cfg_r[`MCDC_TURBO_BIT]) begin
         osr_len = `MCDC_OSR_TURBO;   // [R12]
      end else begin
         osr_len = `MCDC_OSR_BASE << clock_cfg_r[`MCDC_OSR_LSB +: 3];   // [R12]
      end
   end

   // Nominal modulator rate from the configured main clock
   always @* begin
      case (clock_cfg_r[`MCDC_DIV_LSB +: 2])
         `MCDC_DIV_2:  fmod_khz = FMOD_2;
         `MCDC_DIV_4:  fmod_khz = FMOD_4;
         `MCDC_DIV_8:  fmod_khz = FMOD_8;
         `MCDC_DIV_12: fmod_khz = FMOD_12;
         default:      fmod_khz = FMOD_2;
      endcase
   end

   // Range edges in kHz; a kHz grid loses the odd fraction at the edges
   // Neighbouring codes share an edge, so both match exactly there
   always @* begin
      case (conv_code_r)   // [R9]
         4'h0: begin
            lo_khz = 16'h0EB8;
            hi_khz = 16'h1004;
         end
         4'h1: begin
            lo_khz = 16'h0D26;
            hi_khz = 16'h0EB8;
         end
         4'h2: begin
            lo_khz = 16'h0BE1;
            hi_khz = 16'h0D26;
         end
         4'h3: begin
            lo_khz = 16'h0AD5;
            hi_khz = 16'h0BE1;
         end
         4'h4: begin
            lo_khz = 16'h09F5;
            hi_khz = 16'h0AD5;
         end
         4'h5: begin
            lo_khz = 16'h0936;
            hi_khz = 16'h09F5;
         end
         4'h6: begin
            lo_khz = 16'h0892;
            hi_khz = 16'h0936;
         end
         4'h7: begin
            lo_khz = 16'h0803;
            hi_khz = 16'h0892;
         end
         4'h8: begin
            lo_khz = 16'h0786;
            hi_khz = 16'h0803;
         end
         4'h9: begin
            lo_khz = 16'h0717;
            hi_khz = 16'h0786;
         end
         4'hA: begin
            lo_khz = 16'h06B4;
            hi_khz = 16'h0717;
         end
         4'hB: begin
            lo_khz = 16'h065B;
            hi_khz = 16'h06B4;
         end
         4'hC: begin
            lo_khz = 16'h060B;
            hi_khz = 16'h065B;
         end
         4'hD: begin
            lo_khz = 16'h05C3;
            hi_khz = 16'h060B;
         end
         4'hE: begin
            lo_khz = 16'h0581;
            hi_khz = 16'h05C3;
         end
         4'hF: begin
            lo_khz = 16'h0578;
            hi_khz = 16'h0581;
         end
         default: begin
            lo_khz = 16'h0578;
            hi_khz = 16'h1004;
         end
      endcase
   end

   // Register writes
   // Clock word bits 15:9 are stored as zero
   always @(posedge core_clk) begin
      if (!rst_n) begin
         clock_cfg_r <= `MCDC_CLOCK_RST;   // [R15]
         conv_code_r <= `MCDC_CONV_RST;    // [R8]
         ch_sel_r    <= {3{`MCDC_CHSEL_RST}};
      end else if (ce && reg_wr) begin
         case (reg_addr)
            `MCDC_ADDR_CLOCK: clock_cfg_r <= reg_wdata & `MCDC_CLOCK_MASK;   // [R7]
            `MCDC_ADDR_CONV:  conv_code_r <= reg_wdata[3:0];   // [R8]
            `MCDC_ADDR_CH0:   ch_sel_r[1:0] <= reg_wdata[1:0];   // [R1]
            `MCDC_ADDR_CH1:   ch_sel_r[3:2] <= reg_wdata[1:0];   // [R1]
            `MCDC_ADDR_CH2:   ch_sel_r[5:4] <= reg_wdata[1:0];   // [R1]
            default: ;
         endcase
      end
   end

   // Read mux, answered one cycle after the strobe
   always @* begin
      rdata_nxt = 16'h0000;
      case (reg_addr)
         `MCDC_ADDR_CLOCK:  rdata_nxt = clock_cfg_r;
         `MCDC_ADDR_CONV:   rdata_nxt = {12'h000, conv_code_r};
         `MCDC_ADDR_CH0:    rdata_nxt = {14'h0000, ch_sel_r[1:0]};
         `MCDC_ADDR_CH1:    rdata_nxt = {14'h0000, ch_sel_r[3:2]};
         `MCDC_ADDR_CH2:    rdata_nxt = {14'h0000, ch_sel_r[5:4]};
         `MCDC_ADDR_STATUS: rdata_nxt = {13'h0000, ~standby, modulator_clock, range_ok_r};
         default:           rdata_nxt = 16'h0000;
      endcase
   end

   // Idle cycles return zero, so a late sample cannot pass as data
   always @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rdata_nxt : 16'h0000;
      end
   end

   // Bias mode outputs; reserved codes fall back to low power
   always @(posedge core_clk) begin
      if (!rst_n) begin
         high_resolution_mode <= 1'b1;
         low_power_mode       <= 1'b0;
         range_ok_r           <= 1'b0;
      end else if (ce) begin
         high_resolution_mode <= (clock_cfg_r[`MCDC_PWR_LSB +: 2] == `MCDC_PWR_HR);   // [R4]
         low_power_mode       <= (clock_cfg_r[`MCDC_PWR_LSB +: 2] != `MCDC_PWR_HR);   // [R4]
         range_ok_r           <= range_lo_ok && range_hi_ok;   // [R9]
      end
   end

   // Shared test source: first-order stream at density 17/30
   // Never cleared by a window restart, so its phase carries over
   always @* begin
      test_sum = {1'b0, test_acc_r} + {1'b0, `MCDC_TEST_STEP};
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         test_acc_r <= 5'h00;
         test_pos_r <= 1'b0;
         gnd_bit_r  <= 1'b0;
      end else if (ce && mod_tick) begin
         gnd_bit_r <= ~gnd_bit_r;
         if (test_sum >= {1'b0, `MCDC_TEST_MOD}) begin
            test_acc_r <= test_sum[4:0] - `MCDC_TEST_MOD;   // [R2]
            test_pos_r <= 1'b1;
         end else begin
            test_acc_r <= test_sum[4:0];   // [R2]
            test_pos_r <= 1'b0;
         end
      end
   end

   // Window counter; any ratio write restarts the window
   // Strobe lines up with the new words on all three channels
   always @(posedge core_clk) begin
      if (!rst_n) begin
         win_cnt_r  <= 15'h0000;
         data_valid <= 1'b0;
      end else if (ce) begin
         data_valid <= 1'b0;
         if (standby || clk_wr) begin
            win_cnt_r <= 15'h0000;   // [R13]
         end else if (mod_tick) begin
            if (win_end) begin
               win_cnt_r  <= 15'h0000;   // [R14]
               data_valid <= 1'b1;   // [R11]
            end else begin
               win_cnt_r <= win_cnt_r + 15'h0001;
            end
         end
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
         reg  [14:0] acc_r;
         reg  [14:0] dat_r;
         reg         bit_sel;
         wire [14:0] acc_sum;

         assign acc_sum = acc_r + {14'h0000, bit_sel};
         assign data_w[ch*15 +: 15] = dat_r;

         always @* begin
            // Ground stream alternates, so it averages to mid-scale
            case (ch_sel_r[ch*2 +: 2])   // [R1]
               `MCDC_SEL_INPUT: bit_sel = mod_bit_in[ch];   // [R10]
               `MCDC_SEL_GND:   bit_sel = gnd_bit_r;
               `MCDC_SEL_TPOS:  bit_sel = test_pos_r;   // [R1]
               `MCDC_SEL_TNEG:  bit_sel = ~test_pos_r;   // [R2]
               default:         bit_sel = mod_bit_in[ch];
            endcase
         end

         // Sinc1 average: ones count over the window
         always @(posedge core_clk) begin
            if (!rst_n) begin
               acc_r <= 15'h0000;
               dat_r <= 15'h0000;
            end else if (ce) begin
               if (standby || clk_wr) begin
                  acc_r <= 15'h0000;
               end else if (mod_tick) begin
                  if (win_end) begin
                     dat_r <= acc_sum;   // [R11]
                     acc_r <= 15'h0000;
                  end else begin
                     acc_r <= acc_sum;   // [R10]
                  end
               end
            end
         end
      end
   endgenerate
endmodule // mcdc_ctrl

// >>> mcdc_mod_model.sv
// Purpose: stands in for the three channel modulators
// Assumes: bench changes levels only between windows
// Notes:   a fresh bit follows each modulator clock rise
`timescale 1ns/10ps
module mcdc_mod_model (
   input  wire        core_clk,
   input  wire        modulator_clock,
   input  wire [2:0]  level,
   output logic [2:0] bits
);
   logic mclk_q = 1'b0;
   initial bits = 3'h0;
   always @(posedge core_clk) begin
      mclk_q <= modulator_clock;
      if (modulator_clock && !mclk_q) begin
         bits <= level;
      end
   end
endmodule // mcdc_mod_model

// >>> mcdc_ctrl_sva.sv
// Purpose: port checker for mcdc_ctrl
// Assumes: ce drops only while no transfer runs
// Notes:   counters saturate so long windows never wrap
`timescale 1ns/10ps
module mcdc_ctrl_sva (
   input wire        core_clk,
   input wire        rst_n,
   input wire        ce,
   input wire [3:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [15:0] reg_rdata,
   input wire [2:0]  mod_bit_in,
   input wire        modulator_clock,
   input wire        high_resolution_mode,
   input wire        low_power_mode,
   input wire [3:0]  converter_freq_code,
   input wire [14:0] data_ch0,
   input wire [14:0] data_ch1,
   input wire [14:0] data_ch2,
   input wire        data_valid
);
   logic [2:0] run_r;
   logic [7:0] gap_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Cycles the modulator clock has stood still
   always_ff @(posedge core_clk) begin
      if (!rst_n || $changed(modulator_clock)) begin
         run_r <= 3'h0;
      end else if (ce && run_r != 3'h7) begin
         run_r <= run_r + 3'h1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         gap_r <= 8'hFF;
      end else if (data_valid) begin
         gap_r <= 8'h00;
      end else if (gap_r != 8'hFF) begin
         gap_r <= gap_r + 8'h01;
      end
   end
   sequence s_clk_wr;
      ce && reg_wr && reg_addr == 4'h0;
   endsequence
   sequence s_conv_wr;
      ce && reg_wr && reg_addr == 4'h1;
   endsequence
   property p_mode_excl;
      high_resolution_mode != low_power_mode;
   endproperty
   property p_mode_wr;
      s_clk_wr |-> ##2 high_resolution_mode == ($past(reg_wdata[1:0], 2) == 2'h0);
   endproperty
   property p_div_reset;
      $rose(rst_n) |-> ##[0:2] $rose(modulator_clock);
   endproperty
   property p_half_max;
      run_r < 3'h6;
   endproperty
   property p_code_wr;
      s_conv_wr |=> converter_freq_code == $past(reg_wdata[3:0]);
   endproperty
   property p_dv_pulse;
      data_valid |=> !data_valid;
   endproperty
   property p_dv_gap;
      data_valid |-> gap_r >= 8'h70;
   endproperty
   property p_wr_quiet;
      s_clk_wr |=> ##1 !data_valid [*8];
   endproperty
   a_mode_excl: assert property (p_mode_excl) else $error("power mode outputs clash");
   a_mode_wr: assert property (p_mode_wr) else $error("power mode not applied");
   a_div_reset: assert property (p_div_reset) else $error("no divide by two after reset");
   a_half_max: assert property (p_half_max) else $error("modulator half period too long");
   a_code_wr: assert property (p_code_wr) else $error("converter code not applied");
   a_dv_pulse: assert property (p_dv_pulse) else $error("data valid too long");
   a_dv_gap: assert property (p_dv_gap) else $error("data valid too early");
   a_wr_quiet: assert property (p_wr_quiet) else $error("data after clock write");
endmodule // mcdc_ctrl_sva
bind mcdc_ctrl mcdc_ctrl_sva i_mcdc_ctrl_sva (.*);

// >>> mcdc_ctrl_bench.sv
// Purpose: self-checking bench for mcdc_ctrl
// Assumes: main clock 250 MHz, ce dropped once to check the freeze
// Notes:   long ratios run only at divide by two to keep runtime low
`timescale 1ns/10ps
`include "mcdc_defines.vh"
module mcdc_ctrl_bench;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ce = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [2:0]  level = 3'h0;
   wire  [15:0] reg_rdata;
   wire  [2:0]  mod_bit_in;
   wire         modulator_clock;
   wire         high_resolution_mode;
   wire         low_power_mode;
   wire  [3:0]  converter_freq_code;
   wire  [14:0] data_ch0;
   wire  [14:0] data_ch1;
   wire  [14:0] data_ch2;
   wire         data_valid;
   integer      seed = 32'h9ceb;
   integer      bad_count = 0;
   integer      checks = 0;
   integer      i, n, h, l, ov, nd;
   logic [15:0] d, v;
   mcdc_ctrl #(.MAIN_CLK_KHZ(`MCDC_MAIN_KHZ)) i_mcdc_ctrl (.*);
   mcdc_mod_model i_mcdc_mod_model (.core_clk(core_clk), .modulator_clock(modulator_clock), .level(level), .bits(mod_bit_in));
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   task tally_and_finish;
      if (bad_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] w);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] q);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   // Ratio only ever changes while in standby
   task automatic setclk(input logic [15:0] w);
      wr(`MCDC_ADDR_CLOCK, w | 16'h0100);
      wr(`MCDC_ADDR_CLOCK, w);
   endtask
   task automatic wait_valid(input integer lim, output integer c);
      c = 0;
      do begin
         @(posedge core_clk);
         #1;
         c = c + 1;
         if (c > lim) begin
            bad_count = bad_count + 1;
            tally_and_finish;
         end
      end while (data_valid !== 1'b1);
   endtask
   task automatic edge_to(input logic lv, output integer c);
      c = 0;
      while (modulator_clock !== lv) begin
         @(posedge core_clk);
         #1;
         c = c + 1;
         if (c > 40) begin
            bad_count = bad_count + 1;
            tally_and_finish;
         end
      end
   endtask
   function automatic integer osr_of(input logic t, input logic [2:0] r);
      return t ? 64 : 128 << r;
   endfunction
   function automatic integer half_of(input integer s);
      return (s == 3) ? 6 : 1 << s;
   endfunction
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`MCDC_ADDR_CLOCK, d);
      chk(d, `MCDC_CLOCK_RST);
      chk({high_resolution_mode, low_power_mode, converter_freq_code}, 6'h20);
      rd({1'b1, 3'($random(seed))}, d);
      chk(d, 0);
      for (i = 0; i < 4; i = i + 1) begin
         v = ($random(seed) & 16'hFE00) | 16'h0100 | 16'(i);
         wr(`MCDC_ADDR_CLOCK, v);
         rd(`MCDC_ADDR_CLOCK, d);
         chk(d, v & `MCDC_CLOCK_MASK);
         chk({high_resolution_mode, low_power_mode}, (i == 0) ? 2 : 1);
      end
      for (i = 0; i < 16; i = i + 1) begin
         wr(`MCDC_ADDR_CONV, ($random(seed) & 16'hFFF0) | 16'(i));
         chk(converter_freq_code, i);
      end
      for (i = 0; i < 4; i = i + 1) begin
         wr(`MCDC_ADDR_CLOCK, (i > 1) ? 16'h0104 : 16'h0100);
         wr(`MCDC_ADDR_CONV, (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 8 : 7);
         rd(`MCDC_ADDR_STATUS, d);
         chk(d[0], (i % 2) == 0);
      end
      for (i = 0; i < 4; i = i + 1) begin
         wr(`MCDC_ADDR_CLOCK, 16'h0100 | 16'(i << 2));
         // New ratio loads at the first fall after the write
         edge_to(1'b0, n);
         edge_to(1'b1, n);
         edge_to(1'b0, n);
         edge_to(1'b1, l);
         edge_to(1'b0, h);
         chk(h, half_of(i));
         chk(h + l, 2 * half_of(i));
      end
      level <= 3'h1;
      for (i = 0; i < 10; i = i + 1) begin
         v = (i == 0) ? 16'h0080 : (i == 9) ? 16'h008C : 16'((i - 1) << 4);
         ov = osr_of(v[7], v[6:4]);
         nd = (i == 9) ? 12 : 2;
         setclk(v);
         wait_valid(ov * nd + 40, n);
         chk(data_ch0, ov);
         chk(data_ch1, 0);
         if (i < 2 || i == 9) begin
            wait_valid(ov * nd + 40, n);
            chk(n, ov * nd);
         end
      end
      wr(`MCDC_ADDR_CH0, `MCDC_SEL_TPOS);
      wr(`MCDC_ADDR_CH1, `MCDC_SEL_TNEG);
      wr(`MCDC_ADDR_CH2, `MCDC_SEL_GND);
      setclk(16'h0030);
      wait_valid(2100, n);
      chk(data_ch0 + data_ch1, 1024);
      chk(data_ch2, 512);
      chk(data_ch0 > 572 && data_ch0 < 589, 1);
      rd(`MCDC_ADDR_CH0, d);
      chk(d, `MCDC_SEL_TPOS);
      // Clock enable low must freeze the divider as well
      @(posedge core_clk);
      ce <= 1'b0;
      #1 l = modulator_clock;
      repeat (4) @(posedge core_clk);
      #1 chk(modulator_clock, l);
      @(posedge core_clk);
      ce <= 1'b1;
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`MCDC_ADDR_CLOCK, d);
      chk(d, `MCDC_CLOCK_RST);
      chk({high_resolution_mode, low_power_mode, converter_freq_code, data_valid}, 7'h40);
      wr(`MCDC_ADDR_CONV, `MCDC_CONV_RST);
      rd(`MCDC_ADDR_STATUS, d);
      chk({d[2], d[0]}, 2'h1);
      tally_and_finish;
   end
endmodule // mcdc_ctrl_bench
